// ---- common/lici_pkg.sv ----
// line interface control registers: shared constants and types
// assumes a host port of 8-bit data with single-cycle read and write strobes
package lici_pkg;

    // ------------------------------------------------------------
    // primary bank offsets
    // ------------------------------------------------------------
    localparam logic [7:0] LICI_OFF_TEMPLATE = 8'h11;
    localparam logic [7:0] LICI_OFF_DRV_OE = 8'h12;
    localparam logic [7:0] LICI_OFF_ALARM_STAT = 8'h13;
    localparam logic [7:0] LICI_OFF_ALARM_MASK = 8'h14;
    localparam logic [7:0] LICI_OFF_ALARM_FLAG = 8'h15;
    localparam logic [7:0] LICI_OFF_BANK_PTR = 8'h1F;

    // ------------------------------------------------------------
    // expanded bank offsets
    // ------------------------------------------------------------
    localparam logic [7:0] LICI_OFF_RAIL_FORCE = 8'h00;
    localparam logic [7:0] LICI_OFF_LINE_CODE = 8'h01;
    localparam logic [7:0] LICI_OFF_CLK_REC_OFF = 8'h02;
    localparam logic [7:0] LICI_OFF_RX_PDN = 8'h03;
    localparam logic [7:0] LICI_OFF_TX_PDN = 8'h04;

    // ------------------------------------------------------------
    // values and fields
    // ------------------------------------------------------------
    localparam logic [7:0] LICI_BANK_PRIMARY = 8'h00;
    localparam logic [7:0] LICI_BANK_EXPANDED = 8'hAA;
    localparam logic [7:0] LICI_RST_REG = 8'h00;
    localparam logic [7:0] LICI_RST_TEMPLATE = 8'h00;
    localparam int LICI_TEMPLATE_MSB = 2;
    localparam logic [2:0] LICI_TPL_E1 = 3'h0;
    localparam logic [2:0] LICI_TPL_T1_FIRST = 3'h3;
    localparam logic [7:0] LICI_TEMPLATE_MASK = 8'h07;

    // pulse shape families decoded from the template code
    typedef enum logic [1:0] {
        LICI_SHAPE_E1,
        LICI_SHAPE_RESERVED,
        LICI_SHAPE_T1
    } lici_shape_t;

endpackage

// ---- hdl/lici_alarm_chan.sv ----
// one channel of alarm status, change detect and latched flag
// assumes the alarm level is synchronous to clk_sys
`timescale 1ns/1ns
module lici_alarm_chan
    import lici_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic alarm_in,
    input wire logic irq_mask,
    input wire logic flag_clear,
    output logic status_q,
    output logic flag_q
);

    logic change;

    // ------------------------------------------------------------
    // status and flag
    // ------------------------------------------------------------

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= 1'b0;
        end else begin
            status_q <= alarm_in;
        end
    end

    // rising or falling edge of the status bit
    assign change = alarm_in ^ status_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else if (change && irq_mask) begin
            flag_q <= 1'b1;
        end else if (flag_clear) begin
            flag_q <= 1'b0;
        end
    end

endmodule

// ---- hdl/lici_regs.sv ----
// control and status register bank of the octal line interface
// assumes host strobes and line status inputs are synchronous to clk_sys
`timescale 1ns/1ns
module lici_regs
    import lici_pkg::*;
#(
    parameter int NUM_CH = 8
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata_q,
    output logic host_rvalid_q,
    input wire logic [NUM_CH-1:0] alarm_detect,
    input wire logic [NUM_CH-1:0] tx_negative_data_pin,
    input wire logic [NUM_CH-1:0] tx_clock_pin,
    output logic [2:0] pulse_template_code_q,
    output logic template_is_t1_q,
    output logic template_reserved_q,
    output logic expanded_bank_q,
    output logic [NUM_CH-1:0] tx_driver_hiz_q,
    output logic [NUM_CH-1:0] single_rail_q,
    output logic [NUM_CH-1:0] line_code_ami_q,
    output logic [NUM_CH-1:0] clock_recovery_off_q,
    output logic [NUM_CH-1:0] rx_power_down_q,
    output logic [NUM_CH-1:0] tx_power_down_q
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] template_q;
    logic [NUM_CH-1:0] drv_oe_q;
    logic [NUM_CH-1:0] alarm_irq_mask;
    logic [7:0] bank_pointer;
    logic [NUM_CH-1:0] rail_mode_force;
    logic [NUM_CH-1:0] line_code_bit;
    logic [NUM_CH-1:0] clock_recovery_off;
    logic [NUM_CH-1:0] rx_power_down;
    logic [NUM_CH-1:0] tx_power_down;
    logic [NUM_CH-1:0] alarm_status;
    logic [NUM_CH-1:0] alarm_irq_flag;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic in_expanded;
    logic wr_pri;
    logic wr_ext;
    logic rd_pri;
    logic flag_rd;
    logic [7:0] rd_mux;
    lici_shape_t shape;

    assign in_expanded = (bank_pointer == LICI_BANK_EXPANDED);
    assign wr_pri = host_wr && !in_expanded;
    assign wr_ext = host_wr && in_expanded;
    assign rd_pri = host_rd && !in_expanded;
    assign flag_rd = rd_pri && (host_addr == LICI_OFF_ALARM_FLAG);

    // ------------------------------------------------------------
    // bank pointer
    // ------------------------------------------------------------

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bank_pointer <= LICI_BANK_PRIMARY;
        end else if (host_wr && host_addr == LICI_OFF_BANK_PTR) begin
            bank_pointer <= host_wdata;
        end
    end

    // ------------------------------------------------------------
    // primary bank writes
    // ------------------------------------------------------------

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            template_q <= LICI_RST_TEMPLATE;
        end else if (wr_pri && host_addr == LICI_OFF_TEMPLATE) begin
            template_q <= host_wdata & LICI_TEMPLATE_MASK;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            drv_oe_q <= LICI_RST_REG[NUM_CH-1:0];
        end else if (wr_pri && host_addr == LICI_OFF_DRV_OE) begin
            drv_oe_q <= host_wdata[NUM_CH-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            alarm_irq_mask <= LICI_RST_REG[NUM_CH-1:0];
        end else if (wr_pri && host_addr == LICI_OFF_ALARM_MASK) begin
            alarm_irq_mask <= host_wdata[NUM_CH-1:0];
        end
    end

    // ------------------------------------------------------------
    // expanded bank writes
    // ------------------------------------------------------------

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rail_mode_force <= LICI_RST_REG[NUM_CH-1:0];
        end else if (wr_ext && host_addr == LICI_OFF_RAIL_FORCE) begin
            rail_mode_force <= host_wdata[NUM_CH-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            line_code_bit <= LICI_RST_REG[NUM_CH-1:0];
        end else if (wr_ext && host_addr == LICI_OFF_LINE_CODE) begin
            line_code_bit <= host_wdata[NUM_CH-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clock_recovery_off <= LICI_RST_REG[NUM_CH-1:0];
        end else if (wr_ext && host_addr == LICI_OFF_CLK_REC_OFF) begin
            clock_recovery_off <= host_wdata[NUM_CH-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_power_down <= LICI_RST_REG[NUM_CH-1:0];
        end else if (wr_ext && host_addr == LICI_OFF_RX_PDN) begin
            rx_power_down <= host_wdata[NUM_CH-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_power_down <= LICI_RST_REG[NUM_CH-1:0];
        end else if (wr_ext && host_addr == LICI_OFF_TX_PDN) begin
            tx_power_down <= host_wdata[NUM_CH-1:0];
        end
    end

    // ------------------------------------------------------------
    // alarm channels
    // ------------------------------------------------------------

    // one status and flag cell per channel
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_alarm
        lici_alarm_chan u_chan (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .alarm_in(alarm_detect[ch]),
            .irq_mask(alarm_irq_mask[ch]),
            .flag_clear(flag_rd),
            .status_q(alarm_status[ch]),
            .flag_q(alarm_irq_flag[ch])
        );
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------

    // select read data; unmapped offsets read zero
    always_comb begin
        rd_mux = 8'h00;
        if (host_addr == LICI_OFF_BANK_PTR) begin
            rd_mux = bank_pointer;
        end else if (in_expanded) begin
            case (host_addr)
                LICI_OFF_RAIL_FORCE: rd_mux[NUM_CH-1:0] = rail_mode_force;
                LICI_OFF_LINE_CODE: rd_mux[NUM_CH-1:0] = line_code_bit;
                LICI_OFF_CLK_REC_OFF: rd_mux[NUM_CH-1:0] = clock_recovery_off;
                LICI_OFF_RX_PDN: rd_mux[NUM_CH-1:0] = rx_power_down;
                LICI_OFF_TX_PDN: rd_mux[NUM_CH-1:0] = tx_power_down;
                default: rd_mux = 8'h00;
            endcase
        end else begin
            case (host_addr)
                LICI_OFF_TEMPLATE: rd_mux = template_q;
                LICI_OFF_DRV_OE: rd_mux[NUM_CH-1:0] = drv_oe_q;
                LICI_OFF_ALARM_STAT: rd_mux[NUM_CH-1:0] = alarm_status;
                LICI_OFF_ALARM_MASK: rd_mux[NUM_CH-1:0] = alarm_irq_mask;
                LICI_OFF_ALARM_FLAG: rd_mux[NUM_CH-1:0] = alarm_irq_flag;
                default: rd_mux = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            host_rdata_q <= 8'h00;
            host_rvalid_q <= 1'b0;
        end else begin
            host_rvalid_q <= host_rd;
            if (host_rd) begin
                host_rdata_q <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // template decode
    // ------------------------------------------------------------

    always_comb begin
        case (template_q[LICI_TEMPLATE_MSB:0])
            LICI_TPL_E1: shape = LICI_SHAPE_E1;
            3'h1, 3'h2: shape = LICI_SHAPE_RESERVED;
            default: shape = LICI_SHAPE_T1;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pulse_template_code_q <= LICI_TPL_E1;
            template_is_t1_q <= 1'b0;
            template_reserved_q <= 1'b0;
            expanded_bank_q <= 1'b0;
        end else begin
            pulse_template_code_q <= template_q[LICI_TEMPLATE_MSB:0];
            template_is_t1_q <= (shape == LICI_SHAPE_T1);
            template_reserved_q <= (shape == LICI_SHAPE_RESERVED);
            expanded_bank_q <= in_expanded;
        end
    end

    // ------------------------------------------------------------
    // per-channel line controls
    // ------------------------------------------------------------

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_power_down_q <= '0;
            tx_driver_hiz_q <= '0;
        end else begin
            tx_power_down_q <= tx_power_down | ~tx_clock_pin;
            tx_driver_hiz_q <= drv_oe_q | tx_power_down | ~tx_clock_pin;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            single_rail_q <= '0;
            line_code_ami_q <= '0;
            clock_recovery_off_q <= '0;
            rx_power_down_q <= '0;
        end else begin
            single_rail_q <= (rail_mode_force & ~clock_recovery_off) |
                             (~(rail_mode_force & ~clock_recovery_off) & tx_negative_data_pin);
            line_code_ami_q <= line_code_bit & rail_mode_force & ~clock_recovery_off;
            clock_recovery_off_q <= clock_recovery_off;
            rx_power_down_q <= rx_power_down;
        end
    end

endmodule

// ---- bench/lici_regs_sva.sv ----
// checker for the line interface register bank
// assumes a bind to lici_regs and sight of its ports only
`timescale 1ns/1ns
module lici_regs_sva
    import lici_pkg::*;
#(
    parameter int NUM_CH = 8
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata_q,
    input wire logic host_rvalid_q,
    input wire logic [NUM_CH-1:0] alarm_detect,
    input wire logic [NUM_CH-1:0] tx_clock_pin,
    input wire logic [2:0] pulse_template_code_q,
    input wire logic template_is_t1_q,
    input wire logic template_reserved_q,
    input wire logic expanded_bank_q,
    input wire logic [NUM_CH-1:0] tx_driver_hiz_q,
    input wire logic [NUM_CH-1:0] single_rail_q,
    input wire logic [NUM_CH-1:0] line_code_ami_q,
    input wire logic [NUM_CH-1:0] tx_power_down_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // read of the flag register in the primary bank
    sequence s_flag_rd;
        host_rd && host_addr == 8'h15 && !expanded_bank_q;
    endsequence
    a_tpl_t1: assert property (
        $stable(pulse_template_code_q) [*2] |->
        template_is_t1_q == (pulse_template_code_q >= 3'h3)) else $error("t1 flag wrong");
    a_tpl_rsv: assert property (
        $stable(pulse_template_code_q) [*2] |-> template_reserved_q ==
        (pulse_template_code_q inside {3'h1, 3'h2})) else $error("reserved flag wrong");
    a_clk_pin_pdn: assert property (
        1'b1 |=> (tx_power_down_q | $past(tx_clock_pin)) == '1) else $error("clock pin ignored");
    a_pdn_hiz: assert property (
        (tx_power_down_q & ~tx_driver_hiz_q) == '0) else $error("powered down driver live");
    a_ptr_write: assert property (
        host_wr && host_addr == 8'h1F |->
        ##2 expanded_bank_q == ($past(host_wdata, 2) == 8'hAA)) else $error("bank select wrong");
    a_ami_single: assert property (
        (line_code_ami_q & ~single_rail_q) == '0) else $error("ami without single rail");
    a_rd_answer: assert property (
        host_rvalid_q == $past(host_rd)) else $error("read answer timing wrong");
    a_flag_clear: assert property (
        s_flag_rd ##0 $stable(alarm_detect) ##1 s_flag_rd |=> host_rdata_q == 8'h00)
        else $error("flags not cleared by read");
    a_stat_read: assert property (
        host_rd && host_addr == 8'h13 && !expanded_bank_q && $stable(alarm_detect) |=>
        host_rdata_q == $past(alarm_detect)) else $error("status read wrong");
endmodule
bind lici_regs lici_regs_sva #(.NUM_CH(NUM_CH)) i_sva (.clk_sys(clk_sys), .rst_n(rst_n),
    .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
    .host_rdata_q(host_rdata_q), .host_rvalid_q(host_rvalid_q), .alarm_detect(alarm_detect),
    .tx_clock_pin(tx_clock_pin), .pulse_template_code_q(pulse_template_code_q),
    .template_is_t1_q(template_is_t1_q), .template_reserved_q(template_reserved_q),
    .expanded_bank_q(expanded_bank_q), .tx_driver_hiz_q(tx_driver_hiz_q),
    .single_rail_q(single_rail_q), .line_code_ami_q(line_code_ami_q),
    .tx_power_down_q(tx_power_down_q));

// ---- bench/lici_host.sv ----
// host processor model on the register port
// assumes one bench process calls its tasks
`timescale 1ns/1ns
module lici_host
(
    input wire logic clk_sys,
    output logic [7:0] host_addr,
    output logic host_wr,
    output logic host_rd,
    output logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata_q,
    input wire logic host_rvalid_q
);
    logic [7:0] rd_q[$];
    initial begin
        host_addr = 8'h00;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = 8'h00;
    end
    // one transfer per edge, back to back allowed
    task automatic put(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        host_wr <= w;
        host_rd <= r;
        host_addr <= a;
        host_wdata <= d;
    endtask
    // strobes drop low; address and data lines show the inverse of their last value
    task automatic idle();
        put(1'b0, 1'b0, ~host_addr, ~host_wdata);
    endtask
    task automatic ext(input logic w, input logic [7:0] a, input logic [7:0] d);
        put(1'b1, 1'b0, 8'h1F, 8'hAA);
        put(w, ~w, a, d);
        put(1'b1, 1'b0, 8'h1F, 8'h00);
    endtask
    // capture each read answer in the cycle it stands
    always @(posedge clk_sys) begin
        if (host_rvalid_q) begin
            rd_q.push_back(host_rdata_q);
        end
    end
endmodule

// ---- bench/testbench.sv ----
// self-checking bench for the line interface register bank
// assumes the host model and checker files are compiled first
`timescale 1ns/1ns
module testbench;
    logic clk_sys, rst_n, expanded_bank_q, host_wr, host_rd, host_rvalid_q;
    logic template_is_t1_q, template_reserved_q;
    logic [7:0] alarm_detect, tx_negative_data_pin, tx_clock_pin, tx_driver_hiz_q;
    logic [7:0] single_rail_q, line_code_ami_q, clock_recovery_off_q, rx_power_down_q;
    logic [7:0] tx_power_down_q, host_addr, host_wdata, host_rdata_q, v, p, k, eff;
    logic [7:0] e[5];
    logic [7:0] offs[7] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h1F, 8'h20};
    logic [2:0] pulse_template_code_q;
    logic [31:0] lfsr_q = 32'h89F6E9EF;
    logic [7:0] exp_q[$];
    int num_errors = 0;
    int samples_checked = 0;
    lici_regs #(.NUM_CH(8)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .host_addr(host_addr),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
        .host_rdata_q(host_rdata_q), .host_rvalid_q(host_rvalid_q),
        .alarm_detect(alarm_detect), .tx_negative_data_pin(tx_negative_data_pin),
        .tx_clock_pin(tx_clock_pin), .pulse_template_code_q(pulse_template_code_q),
        .template_is_t1_q(template_is_t1_q), .template_reserved_q(template_reserved_q),
        .expanded_bank_q(expanded_bank_q), .tx_driver_hiz_q(tx_driver_hiz_q),
        .single_rail_q(single_rail_q), .line_code_ami_q(line_code_ami_q),
        .clock_recovery_off_q(clock_recovery_off_q), .rx_power_down_q(rx_power_down_q),
        .tx_power_down_q(tx_power_down_q));
    lici_host i_host (.clk_sys(clk_sys), .host_addr(host_addr), .host_wr(host_wr),
        .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata_q(host_rdata_q),
        .host_rvalid_q(host_rvalid_q));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // next random byte from the bench shift register
    function automatic logic [7:0] rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q[7:0];
    endfunction
    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] s);
        samples_checked++;
        if (s !== x) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic rd_exp(input logic [7:0] a, input logic [7:0] x);
        i_host.put(1'b0, 1'b1, a, 8'h00);
        exp_q.push_back(x);
    endtask
    // compare every captured answer with the model queue
    task automatic drain();
        i_host.idle();
        repeat (3) @(posedge clk_sys);
        while (exp_q.size() > 0) begin
            chk("read", exp_q.pop_front(), i_host.rd_q.size() ? i_host.rd_q.pop_front() : 8'hXX);
        end
        chk("extra reads", 8'h00, 8'(i_host.rd_q.size()));
    endtask
    task automatic settle();
        i_host.idle();
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic results();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_sys);
        num_errors++;
        results();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        alarm_detect = 8'h00;
        tx_negative_data_pin = 8'h00;
        tx_clock_pin = 8'hFF;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        // reset values and an unmapped offset
        foreach (offs[i]) rd_exp(offs[i], 8'h00);
        drain();
        chk("bank", 8'h00, expanded_bank_q);
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            i_host.put(1'b1, 1'b0, 8'h11, {v[7:3], i[2:0]});
            rd_exp(8'h11, {5'h00, i[2:0]});
            settle();
            chk("t1", i >= 3, template_is_t1_q);
            chk("rsv", i == 1 || i == 2, template_reserved_q);
            chk("code", i[2:0], pulse_template_code_q);
        end
        v = rnd();
        i_host.put(1'b1, 1'b0, 8'h12, v);
        rd_exp(8'h12, v);
        settle();
        chk("hiz", v, tx_driver_hiz_q);
        i_host.put(1'b1, 1'b0, 8'h12, 8'h00);
        i_host.put(1'b1, 1'b0, 8'h14, 8'h0F);
        i_host.idle();
        alarm_detect <= 8'hFF;
        settle();
        rd_exp(8'h13, 8'hFF);
        rd_exp(8'h15, 8'h0F);
        rd_exp(8'h15, 8'h00);
        rd_exp(8'h14, 8'h0F);
        i_host.idle();
        alarm_detect <= 8'h00;
        settle();
        rd_exp(8'h15, 8'h0F);
        rd_exp(8'h13, 8'h00);
        drain();
        for (int i = 0; i < 5; i++) begin
            e[i] = rnd();
            i_host.ext(1'b1, i[7:0], e[i]);
            i_host.ext(1'b0, i[7:0], 8'h00);
            exp_q.push_back(e[i]);
        end
        rd_exp(8'h00, 8'h00);
        i_host.put(1'b1, 1'b0, 8'h1F, 8'hAA);
        settle();
        chk("bank", 8'h01, expanded_bank_q);
        i_host.put(1'b1, 1'b0, 8'h1F, 8'h00);
        p = rnd();
        k = rnd();
        tx_negative_data_pin <= p;
        tx_clock_pin <= k;
        settle();
        eff = e[0] & ~e[2];
        chk("single", eff | p, single_rail_q);
        chk("ami", e[1] & eff, line_code_ami_q);
        chk("recov", e[2], clock_recovery_off_q);
        chk("rxpd", e[3], rx_power_down_q);
        chk("txpd", e[4] | ~k, tx_power_down_q);
        chk("hiz", e[4] | ~k, tx_driver_hiz_q);
        drain();
        results();
    end
endmodule
